/* rtl/clock_synth.sv */
// Purpose: control logic of a serially programmed square-wave oscillator
// Assumes: SET_WORD/SET_LOAD come from same-clock serial logic; OE is a pin
// Notes:   outputs are a scaled model of the real frequency; FREQ_HZ is exact
//
// Summary of operation
// - internal oscillator 34-68 MHz divided by one of sixteen powers of two
// - frequency = 2^exponent * 2078 Hz / (2 - fine/1024)
// - fine code is an unsigned ten-bit field, 0 to 1023
// - divider exponent is an unsigned four-bit field, 0 to 15
// - reset clears all settings: 1.039 kHz, both outputs on
// - exponent-only change below 10 is immediate; 10 and up settles 100 us
// - fine code change glides smoothly to new frequency within 100 us
// - joint exponent and fine change may overshoot before settling
// - primary and complementary outputs are gated individually by config
// - config 00 both (inverted pair), 01 comp only, 10 prim only, 11 down
// - leaving power-down restarts output at once; SETTLED follows about 100 us later
// - top fine code at one exponent stays below fine zero at next
// - word bits 15:12 exponent, 11:2 fine code, 1:0 config
// - output gate pin low forces both outputs low
`timescale 1ns/1ps
module clock_synth (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  // setting word from the serial front end
  input  wire logic [synth_pkg::WORD_W-1:0]  SET_WORD,
  input  wire logic                          SET_LOAD,
  // asynchronous output gate pin
  input  wire logic                          OE,
  // clock outputs
  output logic                               CLK_P,
  output logic                               CLK_N,
  // status
  output logic [synth_pkg::FREQ_W-1:0]       FREQ_HZ,
  output logic                               SETTLED,
  output logic                               POWERED_DOWN
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // accumulator step for a fine code: oscillator rate is 1/(2048-fine)
  function automatic logic [synth_pkg::ACC_W-1:0] inc_of(
    input logic [synth_pkg::FINE_W-1:0] fine);
    longint den;
    den = 2 * synth_pkg::FINE_DEN - longint'(fine);
    return synth_pkg::ACC_W'(synth_pkg::INC_K / den);
  endfunction

  // exact output frequency in Hz
  function automatic logic [synth_pkg::FREQ_W-1:0] freq_of(
    input logic [synth_pkg::EXP_W-1:0]  expo,
    input logic [synth_pkg::FINE_W-1:0] fine);
    longint num;
    longint den;
    num = (synth_pkg::BASE_HZ * synth_pkg::FINE_DEN) << expo;
    den = 2 * synth_pkg::FINE_DEN - longint'(fine);
    return synth_pkg::FREQ_W'(num / den);
  endfunction

  // ----------------------------------------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n_r;
  logic oe_s1_r;
  logic oe_r;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // gate pin is asynchronous to CLK; costs two cycles of gating latency
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      oe_s1_r <= 1'b0;
      oe_r    <= 1'b0;
    end else begin
      oe_s1_r <= OE;
      oe_r    <= oe_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // setting register and field split
  // ----------------------------------------------------------------------
  logic [synth_pkg::WORD_W-1:0] word_r;
  logic [synth_pkg::EXP_W-1:0]  new_exp;
  logic [synth_pkg::FINE_W-1:0] new_fine;
  synth_pkg::cfg_type           new_cfg;
  logic [synth_pkg::EXP_W-1:0]  cur_exp;
  logic [synth_pkg::FINE_W-1:0] cur_fine;
  synth_pkg::cfg_type           cur_cfg;

  // settings cleared at reset give exponent 0, fine 0, both outputs on
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      word_r <= synth_pkg::WORD_RESET;
    end else if (SET_LOAD) begin
      word_r <= SET_WORD;
    end
  end

  assign new_exp  = SET_WORD[synth_pkg::EXP_LSB  +: synth_pkg::EXP_W];
  assign new_fine = SET_WORD[synth_pkg::FINE_LSB +: synth_pkg::FINE_W];
  assign new_cfg  = synth_pkg::cfg_type'(SET_WORD[synth_pkg::CFG_LSB +: synth_pkg::CFG_W]);
  assign cur_exp  = word_r[synth_pkg::EXP_LSB  +: synth_pkg::EXP_W];
  assign cur_fine = word_r[synth_pkg::FINE_LSB +: synth_pkg::FINE_W];
  assign cur_cfg  = synth_pkg::cfg_type'(word_r[synth_pkg::CFG_LSB +: synth_pkg::CFG_W]);

  // ----------------------------------------------------------------------
  // settling control
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_RUN, ST_SETTLE, ST_DOWN} state_type;

  state_type               state_r;
  state_type               state_nxt;
  logic [synth_pkg::CNT_W-1:0] cnt_r;
  logic [synth_pkg::CNT_W-1:0] cnt_nxt;
  logic                    fine_chg;
  logic                    slow_exp_chg;
  logic                    go_down;
  logic                    wake;

  assign fine_chg     = SET_LOAD && (new_fine != cur_fine);
  assign slow_exp_chg = SET_LOAD && (new_exp != cur_exp) && (new_exp >= synth_pkg::EXP_SLOW);
  assign go_down      = SET_LOAD && (new_cfg == synth_pkg::CFG_DOWN);
  assign wake         = SET_LOAD && (new_cfg != synth_pkg::CFG_DOWN);

  // a fresh change restarts the settle window, so the last write always gets its full time
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_RUN, ST_SETTLE: begin
        if (go_down) begin
          state_nxt = ST_DOWN;
        end else if (fine_chg || slow_exp_chg) begin
          state_nxt = ST_SETTLE;
          cnt_nxt   = synth_pkg::SETTLE_CYC;
        end else if (state_r == ST_SETTLE) begin
          if (cnt_r == '0) begin
            state_nxt = ST_RUN;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
      end
      ST_DOWN: begin
        if (wake) begin
          state_nxt = ST_SETTLE;
          cnt_nxt   = synth_pkg::SETTLE_CYC;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_RUN;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // oscillator model
  // ----------------------------------------------------------------------
  logic [synth_pkg::ACC_W-1:0] target_inc;
  logic [synth_pkg::ACC_W-1:0] inc_r;
  logic [synth_pkg::ACC_W-1:0] inc_nxt;
  logic [synth_pkg::ACC_W:0]   diff;
  logic [synth_pkg::ACC_W:0]   step;
  logic [synth_pkg::ACC_W:0]   acc_sum;
  logic [synth_pkg::ACC_W-1:0] acc_r;
  logic                        osc_run;

  assign target_inc = inc_of(cur_fine);
  assign diff       = {1'b0, target_inc} - {1'b0, inc_r};
  assign step       = $signed(diff) >>> synth_pkg::RAMP_SH;
  // exponential glide, no overshoot; snap once the step rounds to zero
  assign inc_nxt    = (step == '0) ? target_inc
                                   : synth_pkg::ACC_W'({1'b0, inc_r} + step);
  assign osc_run    = (state_r != ST_DOWN);
  assign acc_sum    = {1'b0, acc_r} + {1'b0, inc_r};

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      inc_r <= inc_of('0);
      acc_r <= '0;
    end else begin
      inc_r <= inc_nxt;
      acc_r <= osc_run ? acc_sum[synth_pkg::ACC_W-1:0] : acc_r;
    end
  end

  osc_if osc_bus ();

  assign osc_bus.tick     = osc_run && acc_sum[synth_pkg::ACC_W];
  assign osc_bus.exponent = cur_exp; // exponent takes effect at once

  divider_tap u_div (
    .clk   (CLK),
    .rst_n (rst_n_r),
    .osc   (osc_bus.div)
  );

  // ----------------------------------------------------------------------
  // output gating
  // ----------------------------------------------------------------------
  logic prim_en;
  logic comp_en;

  assign prim_en = oe_r && osc_run &&
                   ((cur_cfg == synth_pkg::CFG_BOTH) || (cur_cfg == synth_pkg::CFG_PRIM));
  assign comp_en = oe_r && osc_run &&
                   ((cur_cfg == synth_pkg::CFG_BOTH) || (cur_cfg == synth_pkg::CFG_COMP));

  // gate pin low drives both outputs low whatever the settings
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      CLK_P        <= 1'b0;
      CLK_N        <= 1'b0;
      FREQ_HZ      <= '0;
      SETTLED      <= 1'b0;
      POWERED_DOWN <= 1'b0;
    end else begin
      CLK_P        <= prim_en & osc_bus.tap;
      CLK_N        <= comp_en & ~osc_bus.tap;    // complementary phase
      FREQ_HZ      <= freq_of(cur_exp, cur_fine);
      SETTLED      <= (state_r == ST_RUN);
      POWERED_DOWN <= (state_r == ST_DOWN);
    end
  end

endmodule

/* rtl/divider_tap.sv */
// Purpose: power-of-two output divider driven by oscillator ticks
// Assumes: tick never asserted in two neighbouring phases faster than clk
// Notes:   free-running counter, tap chosen by the exponent
`timescale 1ns/1ps
module divider_tap (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // oscillator side
  osc_if.div        osc
);

  logic [synth_pkg::DIV_W-1:0] cnt_r;
  logic [synth_pkg::EXP_W-1:0] tap_sel;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  // runs on every tick; never reset by a setting change so tap swaps are glitch-light
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (osc.tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // tap index 15 minus exponent divides by two to the fifteen minus exponent
  assign tap_sel = 4'hf - osc.exponent;
  assign osc.tap = cnt_r[tap_sel];

endmodule

/* rtl/osc_if.sv */
// Purpose: carrier between oscillator model and output divider
// Assumes: single clock domain
// Notes:   tick is a one-cycle pulse per oscillator half period
`timescale 1ns/1ps
interface osc_if;
  logic                       tick;
  logic [synth_pkg::EXP_W-1:0] exponent;
  logic                       tap;

  modport osc (output tick, output exponent, input tap);
  modport div (input tick, input exponent, output tap);
endinterface

/* rtl/synth_pkg.sv */
// Purpose: shared constants and types of the programmable clock synthesiser
// Assumes: 10 MHz system clock, 16-bit setting word from the serial front end
// Notes:   oscillator is modelled by a phase accumulator at a reduced rate
package synth_pkg;

  // ----------------------------------------------------------------------
  // setting word layout
  // ----------------------------------------------------------------------
  localparam int WORD_W    = 16;
  localparam int EXP_W     = 4;
  localparam int FINE_W    = 10;
  localparam int CFG_W     = 2;
  localparam int EXP_LSB   = 12;
  localparam int FINE_LSB  = 2;
  localparam int CFG_LSB   = 0;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // output configuration codes
  typedef enum logic [CFG_W-1:0] {
    CFG_BOTH   = 2'h0,
    CFG_COMP   = 2'h1,
    CFG_PRIM   = 2'h2,
    CFG_DOWN   = 2'h3
  } cfg_type;

  // ----------------------------------------------------------------------
  // frequency law
  // ----------------------------------------------------------------------
  localparam longint BASE_HZ   = 2078;
  localparam longint FINE_DEN  = 1024;
  localparam logic [EXP_W-1:0] EXP_SLOW = 4'ha;
  localparam int FREQ_W    = 32;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ    = 10000000;
  localparam longint SETTLE_US = 100;
  localparam int     CNT_W     = 10;
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((SETTLE_US * CLK_HZ) / 1000000);

  // ----------------------------------------------------------------------
  // oscillator model: accumulator overflows at twice the oscillator rate
  // divided by MODEL_DIV, so the fastest tick stays below the clock
  // ----------------------------------------------------------------------
  localparam int     ACC_W     = 24;
  localparam longint MODEL_DIV = 16;
  localparam longint INC_K     = (BASE_HZ << 50) / (CLK_HZ * MODEL_DIV);
  // glide time constant of 64 cycles, so the widest fine step lands inside the settle window
  localparam int     RAMP_SH   = 6;
  localparam int     DIV_W     = 16;

endpackage

/* verif/clock_synth_asserts.sv */
// Purpose: port-level checks of the clock synthesiser control
// Assumes: one clock domain, RST_N active low
// Notes:   settle length is checked against the package constant
`timescale 1ns/1ps
module clock_synth_asserts (
  // clock and reset
  input wire logic                         CLK,
  input wire logic                         RST_N,
  // settings and gate
  input wire logic [synth_pkg::WORD_W-1:0] SET_WORD,
  input wire logic                         SET_LOAD,
  input wire logic                         OE,
  // outputs
  input wire logic                         CLK_P,
  input wire logic                         CLK_N,
  input wire logic [synth_pkg::FREQ_W-1:0] FREQ_HZ,
  input wire logic                         SETTLED,
  input wire logic                         POWERED_DOWN
);
  // ----------------------------------------------------------------------
  // helper state: last word and length of the current low spell
  // ----------------------------------------------------------------------
  logic [15:0] word_r;
  logic [10:0] low_r;
  wire         fine_chg = SET_LOAD && (SET_WORD[11:2] != word_r[11:2]);
  wire         exp_chg  = SET_LOAD && (SET_WORD[15:12] != word_r[15:12]);
  wire         exp_only = SET_LOAD && (SET_WORD[11:0] == word_r[11:0]);
  // saturates high so the spell that spans reset never counts as short
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      word_r <= 16'h0000;
      low_r  <= 11'h7ff;
    end else begin
      if (SET_LOAD) word_r <= SET_WORD;
      if (SETTLED) low_r <= 11'h000;
      else if (low_r != 11'h7ff) low_r <= low_r + 11'h001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_never_both; !(CLK_P && CLK_N); endproperty
  a_never_both: assert property (p_never_both) else $error("both outputs high");
  property p_down_quiet; POWERED_DOWN && $past(POWERED_DOWN) |-> !CLK_P && !CLK_N; endproperty
  a_down_quiet: assert property (p_down_quiet) else $error("output in power-down");
  property p_down_entry; SET_LOAD && SET_WORD[1:0] == 2'h3 |-> ##2 POWERED_DOWN; endproperty
  a_down_entry: assert property (p_down_entry) else $error("power-down not entered");
  property p_down_unsettled; POWERED_DOWN |-> !SETTLED; endproperty
  a_down_unsettled: assert property (p_down_unsettled) else $error("settled while down");
  property p_gate_low; !OE [*4] |-> !CLK_P && !CLK_N; endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate pin ignored");
  property p_fine_glide; fine_chg |-> ##2 !SETTLED; endproperty
  a_fine_glide: assert property (p_fine_glide) else $error("no settle on fine change");
  property p_exp_slow; exp_chg && SET_WORD[15:12] >= 4'ha |-> ##2 !SETTLED; endproperty
  a_exp_slow: assert property (p_exp_slow) else $error("no settle on high exponent");
  property p_exp_fast;
    exp_only && SET_WORD[15:12] < 4'ha && SETTLED && !$past(SET_LOAD) |-> ##2 SETTLED;
  endproperty
  a_exp_fast: assert property (p_exp_fast) else $error("low exponent not immediate");
  property p_settle_len; $rose(SETTLED) |-> low_r >= 11'(synth_pkg::SETTLE_CYC); endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle spell too short");
endmodule

bind clock_synth clock_synth_asserts chk (.CLK(CLK), .RST_N(RST_N), .SET_WORD(SET_WORD),
  .SET_LOAD(SET_LOAD), .OE(OE), .CLK_P(CLK_P), .CLK_N(CLK_N), .FREQ_HZ(FREQ_HZ),
  .SETTLED(SETTLED), .POWERED_DOWN(POWERED_DOWN));

/* verif/clock_synth_bench.sv */
// Purpose: self-checking bench of the clock synthesiser control
// Assumes: 10 MHz clock, settle window of 1000 cycles
// Notes:   frequency expectations come from the bench's own law
`timescale 1ns/1ps
module clock_synth_bench;
  logic        clk;
  logic        rst_n;
  logic        oe;
  logic [15:0] set_word;
  logic        set_load;
  logic        clk_p;
  logic        clk_n;
  logic [31:0] freq_hz;
  logic        settled;
  logic        powered_down;
  logic [31:0] rnd;
  int          err_count;
  int          checks;
  int          cur_e;
  int          cur_f;
  int          p;
  int          q;
  int          n;
  int          e;
  int          f;
  logic        slow;
  always #50 clk = ~clk;
  host_model host (.clk(clk), .set_word(set_word), .set_load(set_load));
  clock_synth dut (.CLK(clk), .RST_N(rst_n), .SET_WORD(set_word), .SET_LOAD(set_load),
    .OE(oe), .CLK_P(clk_p), .CLK_N(clk_n), .FREQ_HZ(freq_hz), .SETTLED(settled),
    .POWERED_DOWN(powered_down));
  // ----------------------------------------------------------------------
  // reference law, checks and drivers
  // ----------------------------------------------------------------------
  function automatic longint freq(input int ex, input int fn);
    return ((longint'(1) << ex) * synth_pkg::BASE_HZ * synth_pkg::FINE_DEN)
           / (2 * synth_pkg::FINE_DEN - fn);
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic load(input int ex, input int fn, input int c);
    @(posedge clk);
    host.put(4'(ex), 10'(fn), 2'(c), 1'b0);
    repeat (2) @(posedge clk);
    #1;
    cur_e = ex;
    cur_f = fn;
  endtask
  task automatic wait_settled(output int cnt);
    cnt = 0;
    while (settled !== 1'b1 && cnt < 1100) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= 1100) begin
      chk(1'b0, "settle timeout");
    end
  endtask
  task automatic observe(output int hp, output int hn);
    hp = 0;
    hn = 0;
    repeat (64) begin
      @(posedge clk);
      #1;
      hp += int'(clk_p === 1'b1);
      hn += int'(clk_n === 1'b1);
    end
  endtask
  // rising edges of the primary output over a fixed 1000-cycle window
  task automatic count_rises(output int r);
    logic last;
    r = 0;
    last = clk_p;
    repeat (1000) begin
      @(posedge clk);
      #1;
      r += int'(clk_p === 1'b1 && last === 1'b0);
      last = clk_p;
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog: the run needs about 20k cycles
  initial begin
    #5000000;
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    host.idle();
    oe = 1'b0;
    rnd = 32'h00016791;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(freq_hz === 32'(freq(0, 0)) && settled === 1'b1 && powered_down === 1'b0,
        "power-up");
    @(posedge clk);
    oe <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      load(15, 1023, c);
      wait_settled(n);
      observe(p, q);
      chk((p > 0) == (c != 1) && (q > 0) == (c != 2), "output gating");
    end
    @(posedge clk);
    oe <= 1'b0;
    repeat (4) @(posedge clk);
    observe(p, q);
    chk(p + q == 0, "gate pin low");
    @(posedge clk);
    oe <= 1'b1;
    load(15, 1023, 3);
    observe(p, q);
    chk(powered_down === 1'b1 && settled === 1'b0 && p + q == 0, "power-down");
    load(15, 1023, 2);
    wait_settled(n);
    chk(n >= 990 && n < 1100, "wake delay");
    // output rate against the law, scaled by the model divider, at two taps
    for (int x = 15; x > 11; x -= 3) begin
      load(x, 1023, 2);
      wait_settled(n);
      count_rises(p);
      q = int'(freq(x, 1023) * 1000 / (synth_pkg::MODEL_DIV * synth_pkg::CLK_HZ));
      chk(p >= q - 2 && p <= q + 2, "output rate");
    end
    for (int x = 0; x < 15; x++) begin
      load(x, 1023, 2);
      p = int'(freq_hz);
      load(x + 1, 0, 2);
      chk(freq_hz === 32'(freq(x + 1, 0)) && p == freq(x, 1023) && p < freq_hz, "octave");
    end
    @(posedge clk);
    host.put(4'h3, 10'h000, 2'h2, 1'b1);
    host.put(4'h5, 10'h155, 2'h2, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    chk(freq_hz === 32'(freq(5, 341)), "last load wins");
    cur_e = 5;
    cur_f = 341;
    for (int i = 0; i < 14; i++) begin
      wait_settled(n);
      rnd = lfsr(rnd);
      e = int'(rnd[3:0]);
      f = rnd[4] ? cur_f : int'(rnd[14:5]);
      slow = (f != cur_f) || (e != cur_e && e >= 10);
      load(e, f, 2); // primary only, unused output off
      chk(freq_hz === 32'(freq(e, f)), "frequency law");
      chk(settled === !slow, "settle start");
      wait_settled(n);
      chk(n < 1005, "settle length");
    end
    end_of_test();
  end
endmodule

/* verif/host_model.sv */
// Purpose: host controller that writes the setting word
// Assumes: called at a rising clock edge
// Notes:   word line shows the inverse once a load is over
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic                    clk,
  // setting port
  output logic [synth_pkg::WORD_W-1:0] set_word,
  output logic                         set_load
);
  // idle levels, called once at time zero so only the bench process writes the port
  task automatic idle();
    set_word = 16'hffff;
    set_load = 1'b0;
  endtask
  // one load; hold keeps the strobe up for a back-to-back load
  task automatic put(input logic [3:0] e, input logic [9:0] f, input logic [1:0] c,
                     input logic hold);
    set_word <= {e, f, c};
    set_load <= 1'b1;
    @(posedge clk);
    if (!hold) begin
      set_word <= ~{e, f, c};
      set_load <= 1'b0;
    end
  endtask
endmodule
